// File: hdl/i2rb_pkg.sv
package i2rb_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses, one aligned word each)
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W    = 8;          // Decoded address bits
	localparam logic [7:0]  OFS_CTRL  = 8'h00;      // Control
	localparam logic [7:0]  OFS_STAT  = 8'h04;      // Serial status
	localparam logic [7:0]  OFS_RXBUF = 8'h08;      // Holding buffer
	localparam logic [7:0]  OFS_IRQ   = 8'h0c;      // Sticky events, W1C
	localparam logic [7:0]  OFS_MASK  = 8'h10;      // Event mask

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int unsigned CTL_EN    = 0;          // Receiver enable
	localparam int unsigned CTL_MST   = 1;          // Master receiver role
	localparam int unsigned CTL_STT   = 2;          // Start request bit
	localparam int unsigned CTL_OWN   = 8;          // Own address LSB
	localparam int unsigned OWN_W     = 7;          // Own address width
	localparam int unsigned STA_BUSY  = 0;          // Bus busy flag
	localparam int unsigned STA_SCLLO = 1;          // Clock low status
	localparam int unsigned STA_RXF   = 2;          // Rx byte flag
	localparam int unsigned IRQ_RX    = 0;          // Byte loaded
	localparam int unsigned IRQ_ERR   = 1;          // Window fault
	localparam int unsigned IRQ_STA   = 2;          // Start seen
	localparam int unsigned IRQ_STO   = 3;          // Stop seen
	localparam int unsigned IRQ_W     = 4;          // Event count
	localparam int unsigned HTR_ACT   = 1;          // htrans busy/idle bit

	// ------------------------------------------------------------
	// Reset values and bit counts
	// ------------------------------------------------------------
	localparam logic        EN_RST    = 1'b0;       // Receiver off
	localparam logic        MST_RST   = 1'b0;       // Slave role
	localparam logic [3:0]  MASK_RST  = 4'h0;       // All masked
	localparam logic [2:0]  BIT_LAST  = 3'h7;       // Bits before 8th edge
	localparam logic [2:0]  BIT_WIN   = 3'h7;       // Seven bits taken
	localparam logic [2:0]  BIT_ZERO  = 3'h0;       // Fresh byte
	localparam logic [7:0]  BYTE_RST  = 8'h00;      // Empty shift value

	// ------------------------------------------------------------
	// Receive sequencer states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,                       // Waiting for start
		ST_ADDR  = 3'b001,                       // Shifting address
		ST_ACK   = 3'b010,                       // Ninth clock
		ST_DATA  = 3'b011,                       // Shifting data
		ST_STALL = 3'b100,                       // Buffer full, stretch
		ST_HALT  = 3'b101                        // Off the bus to stop
	} i2rb_state_t;

endpackage

// File: hdl/i2rb_rx.sv
// Register access over AHB-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
module i2rb_rx #(
	parameter logic [6:0] OWN_ADDR = 7'h2a      // Slave address at reset
) (
	input  wire logic        clk_i,             // System clock 20 MHz
	input  wire logic        rst_b_i,           // Async reset, low
	input  wire logic        hsel_i,            // AHB select
	input  wire logic [31:0] haddr_i,           // AHB address
	input  wire logic [1:0]  htrans_i,          // AHB transfer type
	input  wire logic        hwrite_i,          // AHB write
	input  wire logic [2:0]  hsize_i,           // AHB size (word only)
	input  wire logic [31:0] hwdata_i,          // AHB write data
	input  wire logic        hready_i,          // AHB bus ready
	output logic      [31:0] hrdata_o,          // AHB read data
	output logic             hreadyout_o,       // AHB slave ready
	output logic             hresp_o,           // AHB response
	input  wire logic        scl_i,             // Clock wire level
	output logic             scl_o,             // Clock drive value
	output logic             scl_oe_o,          // Clock pulled low
	input  wire logic        sda_i,             // Data wire level
	output logic             sda_o,             // Data drive value
	output logic             sda_oe_o,          // Data pulled low
	output logic             irq_o              // Level interrupt
);
	// ------------------------------------------------------------
	// Elaboration check
	// ------------------------------------------------------------
	if (OWN_ADDR == 7'h00) begin : g_chk
		$error("own address must not be the general call address");
	end

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic scl_lvl;                              // Synced clock
	logic scl_rise;                             // Clock rising
	logic scl_fall;                             // Clock falling
	logic sda_lvl;                              // Synced data
	logic sda_rise;                             // Data rising
	logic sda_fall;                             // Data falling

	i2rb_sync #(.RST_VAL(1'b1)) u_scl (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.pin_i   (scl_i),
		.lvl_o   (scl_lvl),
		.rise_o  (scl_rise),
		.fall_o  (scl_fall)
	);

	i2rb_sync #(.RST_VAL(1'b1)) u_sda (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.pin_i   (sda_i),
		.lvl_o   (sda_lvl),
		.rise_o  (sda_rise),
		.fall_o  (sda_fall)
	);

	// Start and stop are data edges while the clock is high
	logic bus_start;                            // Start or repeated start
	logic bus_stop;                             // Stop
	assign bus_start = sda_fall & scl_lvl;
	assign bus_stop  = sda_rise & scl_lvl;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	// Local aliases keep the sequencer readable without an import
	typedef i2rb_pkg::i2rb_state_t i2rb_state_t;
	localparam i2rb_state_t ST_IDLE  = i2rb_pkg::ST_IDLE;  // Waiting
	localparam i2rb_state_t ST_ADDR  = i2rb_pkg::ST_ADDR;  // Address
	localparam i2rb_state_t ST_ACK   = i2rb_pkg::ST_ACK;   // Ninth clock
	localparam i2rb_state_t ST_DATA  = i2rb_pkg::ST_DATA;  // Data bits
	localparam i2rb_state_t ST_STALL = i2rb_pkg::ST_STALL; // Stretching
	localparam i2rb_state_t ST_HALT  = i2rb_pkg::ST_HALT;  // Off the bus
	i2rb_state_t      st_q, st_d;               // Sequencer
	logic [2:0]       bits_q, bits_d;           // Bits taken this byte
	logic [7:0]       shift_q, shift_d;         // Shift register
	logic [7:0]       buf_q, buf_d;             // Holding buffer
	logic             full_q, full_d;           // Rx byte flag
	logic             drv_q, drv_d;             // Drive ACK this ninth bit
	logic             ackf_q, ackf_d;           // Ninth bit under way
	logic             slow_q, slow_d;           // Clock held low
	logic             err_q, err_d;             // Slave fault pending
	logic             busy_q, busy_d;           // Bus busy flag
	logic             clow_q, clow_d;           // Clock low status
	logic             en_q, en_d;               // Receiver enable
	logic             mst_q, mst_d;             // Master role
	logic             stt_q, stt_d;             // Start request bit
	logic [6:0]       own_q, own_d;             // Own address
	logic [3:0]       irq_q, irq_d;             // Sticky events
	logic [3:0]       mask_q, mask_d;           // Event mask
	logic             wph_q, wph_d;             // Write data phase due
	logic [7:0]       wofs_q, wofs_d;           // Write offset
	logic [31:0]      rdat_q, rdat_d;           // Read data register

	// ------------------------------------------------------------
	// AHB-Lite address phase and write data phase decode
	// ------------------------------------------------------------
	logic       acc;                            // Transfer accepted
	logic [7:0] aofs;                           // Low address bits
	logic       rd_buf;                         // Buffer read this cycle
	logic       wr_ctl;                         // Control written
	logic       wr_irq;                         // Events cleared
	logic       wr_msk;                         // Mask written
	assign acc    = hsel_i & hready_i & htrans_i[i2rb_pkg::HTR_ACT];
	assign aofs   = haddr_i[i2rb_pkg::ADDR_W-1:0];
	assign rd_buf = acc & ~hwrite_i & (aofs == i2rb_pkg::OFS_RXBUF);
	assign wr_ctl = wph_q & (wofs_q == i2rb_pkg::OFS_CTRL);
	assign wr_irq = wph_q & (wofs_q == i2rb_pkg::OFS_IRQ);
	assign wr_msk = wph_q & (wofs_q == i2rb_pkg::OFS_MASK);

	// ------------------------------------------------------------
	// Receive sequencer
	// ------------------------------------------------------------
	logic [7:0] byte_in;                        // Byte incl. this bit
	logic       last_edge;                      // Eighth rising edge
	logic       window;                         // High phase, 7th clock
	logic       fault;                          // Read hit the window
	logic       ev_load;                        // Byte entered buffer
	logic       ev_abort;                       // Fault taken
	assign byte_in   = {shift_q[6:0], sda_lvl};
	assign last_edge = scl_rise & (bits_q == i2rb_pkg::BIT_LAST);
	// Only a read of a full buffer during the high phase of the
	// seventh clock upsets the sequencer; the hazard is kept on
	// purpose so software workarounds can be exercised.
	assign window = (st_q == ST_DATA) & (bits_q == i2rb_pkg::BIT_WIN) &
		scl_lvl & ~scl_rise & full_q;
	assign fault  = window & rd_buf;

	always_comb begin
		st_d     = st_q;
		bits_d   = bits_q;
		shift_d  = shift_q;
		buf_d    = buf_q;
		full_d   = full_q;
		drv_d    = drv_q;
		ackf_d   = ackf_q;
		slow_d   = slow_q;
		err_d    = err_q;
		ev_load  = 1'b0;
		ev_abort = 1'b0;
		// A read empties the buffer; a load below wins over it
		if (rd_buf) begin
			full_d = 1'b0;
		end
		if (scl_rise && (st_q == ST_ADDR || st_q == ST_DATA)) begin
			shift_d = byte_in;
			bits_d  = bits_q + 3'h1;
		end
		case (st_q)
			ST_IDLE: begin
				st_d = ST_IDLE;
			end
			ST_ADDR: if (last_edge) begin
				bits_d = i2rb_pkg::BIT_ZERO;
				ackf_d = 1'b0;
				st_d   = ST_ACK;
				// In master role the addressed slave answers
				drv_d  = 1'b0;
				if (!mst_q) begin
					if (byte_in == {own_q, 1'b0}) begin
						drv_d = 1'b1;
					end else begin
						st_d = ST_HALT;
					end
				end
			end
			ST_DATA: if (fault) begin
				ev_abort = 1'b1;
				if (mst_q) begin
					st_d = ST_IDLE;
				end else begin
					err_d = 1'b1;
				end
			end else if (last_edge) begin
				bits_d = i2rb_pkg::BIT_ZERO;
				ackf_d = 1'b0;
				if (err_q) begin
					drv_d = 1'b0;
					st_d  = ST_ACK;
				end else if (!full_q || rd_buf) begin
					buf_d   = byte_in;
					full_d  = 1'b1;
					ev_load = 1'b1;
					drv_d   = 1'b1;
					st_d    = ST_ACK;
				end else begin
					slow_d = 1'b0;
					st_d   = ST_STALL;
				end
			end
			ST_STALL: begin
				if (scl_fall) begin
					slow_d = 1'b1;
				end
				// Hold the clock low until software frees the buffer
				if (!full_q || rd_buf) begin
					buf_d   = shift_q;
					full_d  = 1'b1;
					ev_load = 1'b1;
					drv_d   = 1'b1;
					ackf_d  = slow_q | scl_fall;
					slow_d  = 1'b0;
					st_d    = ST_ACK;
				end
			end
			ST_ACK: if (scl_fall) begin
				if (!ackf_q) begin
					ackf_d = 1'b1;
				end else begin
					drv_d  = 1'b0;
					ackf_d = 1'b0;
					st_d   = err_q ? ST_HALT : ST_DATA;
					err_d  = 1'b0;
				end
			end
			ST_HALT: begin
				st_d = ST_HALT;
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
		// Bus conditions override any byte in flight
		if (bus_stop || !en_q) begin
			st_d  = ST_IDLE;
			err_d = 1'b0;
			drv_d = 1'b0;
		end else if (bus_start) begin
			st_d   = ST_ADDR;
			bits_d = i2rb_pkg::BIT_ZERO;
			err_d  = 1'b0;
			drv_d  = 1'b0;
			ackf_d = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Register file next values
	// ------------------------------------------------------------
	logic [3:0] ev_vec;                         // Event pulses
	assign ev_vec = {bus_stop, bus_start, ev_abort, ev_load};

	always_comb begin
		busy_d = busy_q;
		clow_d = ~scl_lvl;
		en_d   = en_q;
		mst_d  = mst_q;
		stt_d  = stt_q;
		own_d  = own_q;
		mask_d = mask_q;
		irq_d  = irq_q;
		if (bus_start) begin
			busy_d = 1'b1;
		end else if (bus_stop) begin
			busy_d = 1'b0;
		end
		if (wr_ctl) begin
			en_d  = hwdata_i[i2rb_pkg::CTL_EN];
			mst_d = hwdata_i[i2rb_pkg::CTL_MST];
			stt_d = hwdata_i[i2rb_pkg::CTL_STT];
			own_d = hwdata_i[i2rb_pkg::CTL_OWN +: i2rb_pkg::OWN_W];
		end
		// Start request is taken once a start shows on the wire
		if (bus_start) begin
			stt_d = 1'b0;
		end
		if (wr_msk) begin
			mask_d = hwdata_i[i2rb_pkg::IRQ_W-1:0];
		end
		// Clear first, then set, so a same-cycle event survives
		if (wr_irq) begin
			irq_d = irq_d & ~hwdata_i[i2rb_pkg::IRQ_W-1:0];
		end
		irq_d = irq_d | ev_vec;
	end

	// Read data is latched at the address phase, shown in data phase
	always_comb begin
		wph_d  = acc & hwrite_i;
		wofs_d = aofs;
		rdat_d = 32'h0000_0000;
		if (acc && !hwrite_i) begin
			case (aofs)
				i2rb_pkg::OFS_CTRL: begin
					rdat_d[i2rb_pkg::CTL_EN]  = en_q;
					rdat_d[i2rb_pkg::CTL_MST] = mst_q;
					rdat_d[i2rb_pkg::CTL_STT] = stt_q;
					rdat_d[i2rb_pkg::CTL_OWN +: i2rb_pkg::OWN_W] = own_q;
				end
				i2rb_pkg::OFS_STAT: begin
					rdat_d[i2rb_pkg::STA_BUSY]  = busy_q;
					rdat_d[i2rb_pkg::STA_SCLLO] = clow_q;
					rdat_d[i2rb_pkg::STA_RXF]   = full_q;
				end
				i2rb_pkg::OFS_RXBUF: rdat_d[7:0] = buf_q;
				i2rb_pkg::OFS_IRQ:   rdat_d[3:0] = irq_q;
				i2rb_pkg::OFS_MASK:  rdat_d[3:0] = mask_q;
				default:             rdat_d      = 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q    <= ST_IDLE;
			bits_q  <= i2rb_pkg::BIT_ZERO;
			shift_q <= i2rb_pkg::BYTE_RST;
			buf_q   <= i2rb_pkg::BYTE_RST;
			full_q  <= 1'b0;
			drv_q   <= 1'b0;
			ackf_q  <= 1'b0;
			slow_q  <= 1'b0;
			err_q   <= 1'b0;
			busy_q  <= 1'b0;
			clow_q  <= 1'b0;
			en_q    <= i2rb_pkg::EN_RST;
			mst_q   <= i2rb_pkg::MST_RST;
			stt_q   <= 1'b0;
			own_q   <= OWN_ADDR;
			irq_q   <= 4'h0;
			mask_q  <= i2rb_pkg::MASK_RST;
			wph_q   <= 1'b0;
			wofs_q  <= 8'h00;
			rdat_q  <= 32'h0000_0000;
		end else begin
			st_q    <= st_d;
			bits_q  <= bits_d;
			shift_q <= shift_d;
			buf_q   <= buf_d;
			full_q  <= full_d;
			drv_q   <= drv_d;
			ackf_q  <= ackf_d;
			slow_q  <= slow_d;
			err_q   <= err_d;
			busy_q  <= busy_d;
			clow_q  <= clow_d;
			en_q    <= en_d;
			mst_q   <= mst_d;
			stt_q   <= stt_d;
			own_q   <= own_d;
			irq_q   <= irq_d;
			mask_q  <= mask_d;
			wph_q   <= wph_d;
			wofs_q  <= wofs_d;
			rdat_q  <= rdat_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign hrdata_o    = rdat_q;
	assign hreadyout_o = 1'b1;                  // Zero wait states
	assign hresp_o     = 1'b0;                  // Always OKAY
	assign scl_o       = 1'b0;
	assign scl_oe_o    = (st_q == ST_STALL) & slow_q;
	assign sda_o       = 1'b0;
	assign sda_oe_o    = (st_q == ST_ACK) & ackf_q & drv_q;
	assign irq_o       = |(irq_q & mask_q);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	load_sets_flag_a: assert property (ev_load |=> full_q && st_q == ST_ACK && drv_q)
		else $error("load did not set flag and ACK");
	read_clears_a: assert property (rd_buf && !ev_load |=> !full_q)
		else $error("buffer read left flag set");
	full_stalls_a: assert property (st_q == ST_DATA && last_edge && full_q && !rd_buf && !fault && !err_q && !bus_start && !bus_stop && en_q |=> st_q == ST_STALL)
		else $error("full buffer did not stall");
	stall_holds_a: assert property (st_q == ST_STALL && slow_q && full_q && !rd_buf && en_q && !bus_stop && !bus_start |=> scl_oe_o)
		else $error("clock not held during stall");
	master_abort_a: assert property (fault && mst_q |=> st_q == ST_IDLE && irq_q[i2rb_pkg::IRQ_ERR])
		else $error("master fault did not abort");
	slave_nack_a: assert property (err_q && st_q == ST_DATA && last_edge && en_q && !bus_stop && !bus_start |=> st_q == ST_ACK && !drv_q ##1 !sda_oe_o)
		else $error("slave fault did not NACK");
	no_fault_out_a: assert property (rd_buf && !window |=> !(st_q == ST_IDLE && $past(st_q) == ST_DATA && $past(en_q) && !$past(bus_stop)))
		else $error("read outside window upset receiver");
	clock_low_a: assert property (!scl_lvl [*2] |-> clow_q)
		else $error("clock low status not shown");
	irq_level_a: assert property (ev_load && mask_q[i2rb_pkg::IRQ_RX] && !wr_msk |=> irq_o)
		else $error("unmasked event gave no interrupt");
endmodule

// File: hdl/i2rb_sync.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Two-flop pin synchroniser with edge detect on the clean stage
// ------------------------------------------------------------
module i2rb_sync #(
	parameter logic RST_VAL = 1'b1              // Idle wire level
) (
	input  wire logic clk_i,                    // System clock
	input  wire logic rst_b_i,                  // Async reset, low
	input  wire logic pin_i,                    // Raw pin
	output logic      lvl_o,                    // Synced level
	output logic      rise_o,                   // One-cycle rise
	output logic      fall_o                    // One-cycle fall
);
	logic meta_q;                               // First stage only
	logic lvl_q;                                // Second stage
	logic prev_q;                               // Delayed for edges

	// Edges look only at the second stage and its delay
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_q <= RST_VAL;
			lvl_q  <= RST_VAL;
			prev_q <= RST_VAL;
		end else begin
			meta_q <= pin_i;
			lvl_q  <= meta_q;
			prev_q <= lvl_q;
		end
	end

	assign lvl_o  = lvl_q;
	assign rise_o = lvl_q & ~prev_q;
	assign fall_o = ~lvl_q & prev_q;
endmodule

// File: test/i2c_receive_buffer_window_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; \
	if ((got) !== (exp)) begin fails++; \
	$display("mismatch %s exp %h got %h", nm, exp, got); end end
module i2c_receive_buffer_window_tb_top;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        clk_i;                         // System clock
	logic        rst_b_i;                       // Reset, low
	logic        hsel_i;                        // Bus select
	logic [31:0] haddr_i;                       // Bus address
	logic [1:0]  htrans_i;                      // Transfer type
	logic        hwrite_i;                      // Write
	logic [2:0]  hsize_i;                       // Size
	logic [31:0] hwdata_i;                      // Write data
	logic [31:0] hrdata_o;                      // Read data
	logic        hreadyout_o;                   // Slave ready
	logic        hresp_o;                       // Response
	logic        scl_o, scl_oe_o, sda_o, sda_oe_o, irq_o;
	logic        peer_scl, peer_sda;            // Peer drive
	logic        scl_w, sda_w;                  // Resolved wires
	int          fails = 0;                     // Mismatches
	int          samples_checked = 0;           // Comparisons
	int          cycles = 0;                    // Hang guard

	// Open-drain wires with pull-ups
	assign scl_w = peer_scl & ~(scl_oe_o & ~scl_o);
	assign sda_w = peer_sda & ~(sda_oe_o & ~sda_o);

	i2rb_rx u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i),
		.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
		.hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
		.hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
		.scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe_o(sda_oe_o), .irq_o(irq_o));
	i2rb_peer u_peer (.scl_i(scl_w), .sda_i(sda_w), .scl_o(peer_scl),
		.sda_o(peer_sda));

	// ------------------------------------------------------------
	// Clock, hang guard and verdict
	// ------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// A stuck wait ends the run as a failure
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fails++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Bus tasks: hold each phase until ready is sampled high
	// ------------------------------------------------------------
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk_i);
		hsel_i   <= 1'b1;
		htrans_i <= 2'b10;
		haddr_i  <= {24'h000000, a};
		hwrite_i <= w;
		@(posedge clk_i);
		while (hreadyout_o !== 1'b1) @(posedge clk_i);
		htrans_i <= 2'b00;
		hwdata_i <= wd;
		@(posedge clk_i);
		while (hreadyout_o !== 1'b1) @(posedge clk_i);
		rd = hrdata_o;
		`CHK("hresp", 1'b0, hresp_o)
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask
	// Read and compare the bits under the mask
	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		ahb(1'b0, a, 32'h00000000, d);
		`CHK(nm, e, d & m)
	endtask
	task automatic open_frame(input logic [6:0] a, input logic nack);
		logic ack;
		u_peer.start();
		u_peer.xfer({a, 1'b0}, ack);
		`CHK("addr ack", nack, ack)
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Reset values, unmapped place, foreign address, event W1C
	task automatic t_regs();
		rchk("ctrl", i2rb_pkg::OFS_CTRL, 32'hffffffff, 32'h00002a00);
		rchk("mask", i2rb_pkg::OFS_MASK, 32'hffffffff, 32'h00000000);
		rchk("stat", i2rb_pkg::OFS_STAT, 32'hffffffff, 32'h00000000);
		wr(8'h14, 32'hffffffff);
		rchk("unmapped", 8'h14, 32'hffffffff, 32'h00000000);
		wr(i2rb_pkg::OFS_CTRL, 32'h00002a05);
		wr(i2rb_pkg::OFS_MASK, 32'h00000001);
		open_frame(7'h2b, 1'b1);
		u_peer.stop();
		rchk("stt clr", i2rb_pkg::OFS_CTRL, 32'h4, 32'h0);
		rchk("events", i2rb_pkg::OFS_IRQ, 32'h0000000f, 32'h0000000c);
		wr(i2rb_pkg::OFS_IRQ, 32'h0000000c);
		rchk("w1c", i2rb_pkg::OFS_IRQ, 32'h0000000f, 32'h00000000);
		$display("test regs done");
	endtask
	// One byte serviced promptly, interrupt masked and cleared
	task automatic t_rx();
		logic ack;
		open_frame(7'h2a, 1'b0);
		rchk("busy", i2rb_pkg::OFS_STAT, 32'h1, 32'h1);
		u_peer.xfer(8'ha5, ack);
		`CHK("data ack", 1'b0, ack)
		`CHK("irq up", 1'b1, irq_o)
		rchk("flag", i2rb_pkg::OFS_STAT, 32'h4, 32'h4);
		wr(i2rb_pkg::OFS_MASK, 32'h00000000);
		@(posedge clk_i);
		`CHK("irq masked", 1'b0, irq_o)
		wr(i2rb_pkg::OFS_MASK, 32'h00000001);
		@(posedge clk_i);
		`CHK("irq unmasked", 1'b1, irq_o)
		rchk("buf", i2rb_pkg::OFS_RXBUF, 32'hff, 32'ha5);
		rchk("flag clr", i2rb_pkg::OFS_STAT, 32'h4, 32'h0);
		wr(i2rb_pkg::OFS_IRQ, 32'h00000001);
		@(posedge clk_i);
		`CHK("irq clr", 1'b0, irq_o)
		u_peer.stop();
		rchk("free", i2rb_pkg::OFS_STAT, 32'h1, 32'h0);
		$display("test rx done");
	endtask
	// Late read of a full buffer after the given clock rise;
	// rise 8 waits for the stretch and polls clock low first
	task automatic t_win(input int nrise, input logic fault,
		input logic mst);
		logic ack;
		wr(i2rb_pkg::OFS_CTRL, {16'h0000, 8'h2a, 6'h00, mst, 1'b1});
		open_frame(7'h2a, mst);
		u_peer.xfer(8'h3c, ack);
		`CHK("first ack", 1'b0, ack)
		fork
			u_peer.xfer(8'hc3, ack);
			begin
				repeat (nrise) @(posedge scl_w);
				repeat (3) @(posedge clk_i);
				if (nrise == 8) begin
					while (scl_oe_o !== 1'b1) @(posedge clk_i);
					repeat (2) @(posedge clk_i);
					rchk("clk low", i2rb_pkg::OFS_STAT, 32'h2, 32'h2);
					repeat (24) @(posedge clk_i);
					`CHK("stretch", 1'b1, scl_oe_o)
				end
				rchk("old", i2rb_pkg::OFS_RXBUF, 32'hff, 32'h3c);
			end
		join
		`CHK("ack", fault, ack)
		rchk("fault", i2rb_pkg::OFS_IRQ, 32'h2, {30'h0, fault, 1'b0});
		if (!fault) begin
			rchk("new", i2rb_pkg::OFS_RXBUF, 32'hff, 32'hc3);
		end
		wr(i2rb_pkg::OFS_IRQ, 32'h0000000f);
		u_peer.stop();
		$display("test window %0d done", nrise);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst_b_i  = 1'b0;
		hsel_i   = 1'b0;
		haddr_i  = 32'h00000000;
		htrans_i = 2'b00;
		hwrite_i = 1'b0;
		hsize_i  = 3'h2;
		hwdata_i = 32'h00000000;
		repeat (5) @(posedge clk_i);
		rst_b_i <= 1'b1;
		t_regs();
		t_rx();
		t_win(3, 1'b0, 1'b0);
		t_win(7, 1'b1, 1'b0);
		t_win(8, 1'b0, 1'b0);
		t_win(7, 1'b1, 1'b1);
		summarize();
	end
endmodule

// File: test/i2rb_peer.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Peer bus master: open-drain drive, honours clock stretching
// ------------------------------------------------------------
module i2rb_peer #(
	parameter int HALF_NS = 200                 // Half link period
) (
	input  wire logic scl_i,                    // Clock wire level
	input  wire logic sda_i,                    // Data wire level
	output logic      scl_o,                    // Low pulls clock down
	output logic      sda_o                     // Low pulls data down
);
	// Released lines at time zero; the pull-ups idle them high
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	// Start or repeated start; small skew keeps clear of clk edges
	task automatic start();
		#7;
		sda_o = 1'b1;
		#(HALF_NS);
		scl_o = 1'b1;
		wait (scl_i === 1'b1 && sda_i === 1'b1); // Bus free first
		#(HALF_NS);
		sda_o = 1'b0;
		#(HALF_NS);
		scl_o = 1'b0;
	endtask

	// Stop; afterwards the clock stands still high
	task automatic stop();
		#7;
		sda_o = 1'b0;
		#(HALF_NS);
		scl_o = 1'b1;
		wait (scl_i === 1'b1);
		#(HALF_NS);
		sda_o = 1'b1;
		#(HALF_NS);
	endtask

	// One pulse; data moves only while the clock is low
	task automatic pulse(input logic b, output logic r);
		#(HALF_NS / 2);
		sda_o = b;
		#(HALF_NS / 2);
		scl_o = 1'b1;
		wait (scl_i === 1'b1);                  // Device may stretch
		#(HALF_NS / 2 + 3);
		r = sda_i;
		#(HALF_NS / 2);
		scl_o = 1'b0;
	endtask

	// Byte MSB first, then the ninth pulse with data released
	task automatic xfer(input logic [7:0] d, output logic ack);
		logic r;
		#7;
		for (int i = 7; i >= 0; i--) begin
			pulse(d[i], r);
		end
		pulse(1'b1, ack);
	endtask
endmodule
